// >>> inc/scp_pkg.sv
// constants for the system configuration and protection register bank
// assumes a 16-bit internal data port with upper and lower byte enables
package scp_pkg;
	// ***************
	// register offsets from the module base
	// ***************
	localparam logic [11:0] OFF_MODCFG = 12'h000;
	localparam logic [11:0] OFF_PARTID = 12'h002;
	localparam logic [11:0] OFF_AVRRSR = 12'h006;
	localparam logic [11:0] OFF_VECPROT = 12'h020;
	localparam logic [11:0] OFF_TIMING = 12'h024;
	localparam logic [11:0] OFF_SERVICE = 12'h026;
	// base register location in cpu space
	localparam logic [31:0] MBASE_ADDR_HI = 32'h0003ff00;
	localparam logic [31:0] MBASE_ADDR_LO = 32'h0003ff02;
	localparam logic [3:0] FC_CPU = 4'h7;
	localparam logic [3:0] FC_SUP_DATA = 4'h5;
	// ***************
	// field positions
	// ***************
	localparam int MB_VALID = 0;
	localparam int MB_MASK_LO = 1;
	localparam int MB_MASK_HI = 9;
	localparam int MC_FRZ_TMR = 14;
	localparam int MC_FRZ_BM = 13;
	localparam int MC_FULLIRQ = 12;
	localparam int MC_SHOW_HI = 9;
	localparam int MC_SHOW_LO = 8;
	localparam int MC_SUPERVISOR_RESTRICT = 7;
	localparam int SP_WDEN = 7;
	localparam int SP_WDRST = 6;
	localparam int SP_WDT_HI = 5;
	localparam int SP_WDT_LO = 4;
	localparam int SP_DOUBLE_FAULT_MONITOR_ENABLE = 3;
	localparam int SP_BME = 2;
	localparam int PT_PRESCALE = 9;
	// ***************
	// reset values and masks
	// ***************
	localparam logic [15:0] MODCFG_RST = 16'h000f;
	localparam logic [15:0] MODCFG_MASK = 16'h738f;
	localparam logic [31:0] MBASE_MASK = 32'hfffff3ff;
	localparam logic [7:0] VECTOR_RST = 8'h0f;
	localparam logic [7:0] PROT_RST = 8'h00;
	localparam logic [7:0] AVR_MASK = 8'hfe;
	localparam logic [7:0] SVC_FIRST = 8'h55;
	localparam logic [7:0] SVC_SECOND = 8'haa;
	localparam logic [3:0] ARB_OFF = 4'h0;
	// reset source bits
	localparam int RS_PIN = 7;
	localparam int RS_POWER = 6;
	localparam int RS_WDOG = 5;
	localparam int RS_DFAULT = 4;
	localparam int RS_CLKLOSS = 2;
	localparam int RS_INSTR = 1;
	// watchdog timeout exponents, index is prescale and timing bits
	localparam logic [4:0] WD_EXP [8] = '{5'd9, 5'd11, 5'd13, 5'd15, 5'd18, 5'd20, 5'd22, 5'd24};
	localparam int WD_CNT_W = 25;
	// arbitrary identification value
	localparam logic [7:0] PART_ID = 8'h5a;
	typedef enum logic [1:0] {
		SVC_IDLE = 2'b00,
		SVC_ARMED = 2'b01
	} scp_svc_t;
endpackage

// >>> hdl/scp_regs.sv
// configuration and protection register bank with watchdog
// assumes one clock, synchronous inputs, one-cycle bus request strobes
`timescale 1ns/1ps
module scp_regs #(
	parameter int WdShorten = 0
) (
	// clock, reset, enable
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	// internal bus
	input wire logic busSel,
	input wire logic busWrite,
	input wire logic [3:0] busFc,
	input wire logic [31:0] busAddr,
	input wire logic busUpper,
	input wire logic busLower,
	input wire logic [15:0] busWdata,
	output logic busAck_q,
	output logic busErr_q,
	output logic busExternal_q,
	output logic [15:0] busRdata_q,
	// show cycles and arbitration
	input wire logic extBusRequest,
	output logic showDrive_q,
	output logic showDataStrobe_q,
	output logic [15:0] showData_q,
	output logic extRequestSeen_q,
	// freeze and monitors
	input wire logic freeze,
	output logic timersRun_q,
	output logic busMonitorRun_q,
	output logic doubleFaultMonEn_q,
	output logic portFullIrq_q,
	// interrupt acknowledge
	input wire logic iackCycle,
	input wire logic [2:0] iackLevel,
	input wire logic iackWatchdog,
	output logic iackVectorValid_q,
	output logic [7:0] iackVector_q,
	output logic autovectorRequest_q,
	output logic iackExtraneous_q,
	// reset sources
	input wire logic causePin,
	input wire logic causePowerUp,
	input wire logic causeWatchdog,
	input wire logic causeDoubleFault,
	input wire logic causeClockLoss,
	input wire logic instrReset,
	input wire logic modckStrap,
	input wire logic clockLossResetEnable,
	input wire logic oscLoopEnable,
	input wire logic clockLost,
	output logic clockLossReset_q,
	output logic peripheralReset_q,
	// watchdog
	input wire logic crystalTick,
	output logic wdResetReq_q,
	output logic wdIrq7_q
);
	// ***************
	// registers
	// ***************
	logic [31:0] mbase_q;
	logic [15:0] modCfg_q;
	logic [7:0] avr_q;
	logic [7:0] rsr_q;
	logic [7:0] vector_q;
	logic [7:0] prot_q;
	logic protWritten_q;
	logic prescale_q;
	logic captured_q;
	logic [2:0] wdSel_q;
	localparam int CntW = scp_pkg::WD_CNT_W;
	logic [CntW-1:0] wdCount_q;
	scp_pkg::scp_svc_t svc_q;

	// ***************
	// decode
	// ***************
	logic [3:0] spaceIdx;
	logic spaceMasked;
	logic baseHit;
	logic hitHi;
	logic hitLo;
	logic internalHit;
	logic userDenied;
	logic [11:0] off;
	logic wrReg;
	logic showOn;
	logic arbOn;
	logic tmrRun;
	logic [CntW-1:0] wdLimit;
	logic svcWrite;
	logic wdTimeout;

	assign off = busAddr[11:0];
	assign spaceIdx = busFc[3] ? 4'd8 : {1'b0, busFc[2:0]};
	assign spaceMasked = mbase_q[scp_pkg::MB_MASK_LO + 32'(spaceIdx)];
	assign hitHi = busFc == scp_pkg::FC_CPU && busAddr == scp_pkg::MBASE_ADDR_HI;
	assign hitLo = busFc == scp_pkg::FC_CPU && busAddr == scp_pkg::MBASE_ADDR_LO;
	assign baseHit = mbase_q[scp_pkg::MB_VALID] && busAddr[31:12] == mbase_q[31:12] && !spaceMasked;
	assign internalHit = baseHit && (off == scp_pkg::OFF_MODCFG || off == scp_pkg::OFF_PARTID
		|| off == scp_pkg::OFF_AVRRSR || off == scp_pkg::OFF_VECPROT
		|| off == scp_pkg::OFF_TIMING || off == scp_pkg::OFF_SERVICE);
	assign userDenied = modCfg_q[scp_pkg::MC_SUPERVISOR_RESTRICT] && busFc != scp_pkg::FC_SUP_DATA && busWrite;
	assign wrReg = busSel && busWrite && internalHit && !userDenied;
	assign showOn = modCfg_q[scp_pkg::MC_SHOW_HI] || modCfg_q[scp_pkg::MC_SHOW_LO];
	assign arbOn = modCfg_q[scp_pkg::MC_SHOW_HI] || !modCfg_q[scp_pkg::MC_SHOW_LO];
	assign tmrRun = !(freeze && modCfg_q[scp_pkg::MC_FRZ_TMR]);
	assign wdLimit = CntW'(1) << (scp_pkg::WD_EXP[wdSel_q] - 5'(WdShorten));
	assign svcWrite = wrReg && off == scp_pkg::OFF_SERVICE && busLower;
	assign wdTimeout = prot_q[scp_pkg::SP_WDEN] && tmrRun && crystalTick && wdCount_q >= wdLimit - 1'b1;

	// ***************
	// bus answer
	// ***************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			busAck_q <= 1'b0;
			busErr_q <= 1'b0;
			busExternal_q <= 1'b0;
			busRdata_q <= 16'h0000;
		end else if (ce) begin
			busAck_q <= busSel && (hitHi || hitLo || (internalHit && !userDenied));
			busErr_q <= busSel && internalHit && userDenied;
			busExternal_q <= busSel && !hitHi && !hitLo && !internalHit;
			busRdata_q <= 16'h0000;
			if (busSel && !busWrite) begin
				if (hitHi) begin
					busRdata_q <= mbase_q[31:16];
				end else if (hitLo) begin
					busRdata_q <= mbase_q[15:0];
				end else if (internalHit && off == scp_pkg::OFF_MODCFG) begin
					busRdata_q <= modCfg_q;
				end else if (internalHit && off == scp_pkg::OFF_PARTID) begin
					busRdata_q <= {8'h00, scp_pkg::PART_ID};
				end else if (internalHit && off == scp_pkg::OFF_AVRRSR) begin
					busRdata_q <= {avr_q, rsr_q};
				end else if (internalHit && off == scp_pkg::OFF_VECPROT) begin
					busRdata_q <= {vector_q, prot_q};
				end else if (internalHit && off == scp_pkg::OFF_TIMING) begin
					busRdata_q <= 16'(prescale_q) << scp_pkg::PT_PRESCALE;
				end
			end
		end
	end

	// ***************
	// configuration registers
	// ***************
	// instruction reset never touches these
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mbase_q <= 32'h00000000;
			modCfg_q <= scp_pkg::MODCFG_RST;
			avr_q <= 8'h00;
			vector_q <= scp_pkg::VECTOR_RST;
		end else if (ce && busSel && busWrite) begin
			if (hitHi) begin
				mbase_q[31:16] <= busWdata;
			end else if (hitLo) begin
				mbase_q[15:0] <= busWdata & scp_pkg::MBASE_MASK[15:0];
			end else if (wrReg && off == scp_pkg::OFF_MODCFG) begin
				if (busUpper) begin
					modCfg_q[15:8] <= busWdata[15:8] & scp_pkg::MODCFG_MASK[15:8];
				end
				if (busLower) begin
					modCfg_q[7:0] <= busWdata[7:0] & scp_pkg::MODCFG_MASK[7:0];
				end
			end else if (wrReg && off == scp_pkg::OFF_AVRRSR && busUpper) begin
				avr_q <= busWdata[15:8] & scp_pkg::AVR_MASK;
			end else if (wrReg && off == scp_pkg::OFF_VECPROT && busUpper) begin
				vector_q <= busWdata[15:8];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prot_q <= scp_pkg::PROT_RST;
			protWritten_q <= 1'b0;
		end else if (ce && wrReg && off == scp_pkg::OFF_VECPROT && busLower && !protWritten_q) begin
			prot_q <= busWdata[7:0];
			protWritten_q <= 1'b1;
		end
	end

	// strap and reset source captured after release
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			captured_q <= 1'b0;
			prescale_q <= 1'b0;
			rsr_q <= 8'h00;
		end else if (ce) begin
			if (!captured_q) begin
				captured_q <= 1'b1;
				prescale_q <= !modckStrap;
				rsr_q <= 8'h00;
				if (causePowerUp) begin
					rsr_q[scp_pkg::RS_POWER] <= 1'b1;
				end else if (causeClockLoss && clockLossResetEnable && oscLoopEnable) begin
					rsr_q[scp_pkg::RS_CLKLOSS] <= 1'b1;
				end else if (causeWatchdog) begin
					rsr_q[scp_pkg::RS_WDOG] <= 1'b1;
				end else if (causeDoubleFault) begin
					rsr_q[scp_pkg::RS_DFAULT] <= 1'b1;
				end else begin
					rsr_q[scp_pkg::RS_PIN] <= 1'b1;
				end
			end else if (instrReset) begin
				rsr_q <= 8'h00;
				rsr_q[scp_pkg::RS_INSTR] <= 1'b1;
			end else if (wrReg && off == scp_pkg::OFF_TIMING && busUpper) begin
				prescale_q <= busWdata[scp_pkg::PT_PRESCALE];
			end
		end
	end

	// ***************
	// watchdog
	// ***************
	// service sequence applies timeout
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			svc_q <= scp_pkg::SVC_IDLE;
			wdSel_q <= 3'h0;
			wdCount_q <= '0;
		end else if (ce) begin
			if (svcWrite) begin
				svc_q <= busWdata[7:0] == scp_pkg::SVC_FIRST ? scp_pkg::SVC_ARMED : scp_pkg::SVC_IDLE;
			end
			if (svcWrite && svc_q == scp_pkg::SVC_ARMED && busWdata[7:0] == scp_pkg::SVC_SECOND) begin
				wdSel_q <= {prescale_q, prot_q[scp_pkg::SP_WDT_HI:scp_pkg::SP_WDT_LO]};
				wdCount_q <= '0;
			end else if (!prot_q[scp_pkg::SP_WDEN] || wdTimeout) begin
				wdCount_q <= '0;
			end else if (tmrRun && crystalTick) begin
				wdCount_q <= wdCount_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wdResetReq_q <= 1'b0;
			wdIrq7_q <= 1'b0;
		end else if (ce) begin
			wdResetReq_q <= wdTimeout && prot_q[scp_pkg::SP_WDRST];
			if (wdTimeout && !prot_q[scp_pkg::SP_WDRST]) begin
				wdIrq7_q <= 1'b1;
			end else if (iackCycle && iackWatchdog) begin
				wdIrq7_q <= 1'b0;
			end
		end
	end

	// ***************
	// interrupt acknowledge
	// ***************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			iackVectorValid_q <= 1'b0;
			iackVector_q <= 8'h00;
			autovectorRequest_q <= 1'b0;
			iackExtraneous_q <= 1'b0;
		end else if (ce) begin
			iackExtraneous_q <= iackCycle && modCfg_q[3:0] == scp_pkg::ARB_OFF;
			iackVectorValid_q <= iackCycle && iackWatchdog && modCfg_q[3:0] != scp_pkg::ARB_OFF;
			iackVector_q <= iackCycle && iackWatchdog ? vector_q : 8'h00;
			autovectorRequest_q <= iackCycle && !iackWatchdog && avr_q[iackLevel]
				&& modCfg_q[3:0] != scp_pkg::ARB_OFF;
		end
	end

	// ***************
	// pins, show cycles, monitors
	// ***************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			showDrive_q <= 1'b0;
			showDataStrobe_q <= 1'b0;
			showData_q <= 16'h0000;
			extRequestSeen_q <= 1'b0;
			timersRun_q <= 1'b1;
			busMonitorRun_q <= 1'b0;
			doubleFaultMonEn_q <= 1'b0;
			portFullIrq_q <= 1'b0;
			clockLossReset_q <= 1'b0;
			peripheralReset_q <= 1'b0;
		end else if (ce) begin
			showDrive_q <= busSel && internalHit && showOn;
			showDataStrobe_q <= busSel && internalHit && showOn;
			showData_q <= busSel && internalHit && showOn ? busWdata : 16'h0000;
			extRequestSeen_q <= extBusRequest && arbOn;
			timersRun_q <= tmrRun;
			busMonitorRun_q <= prot_q[scp_pkg::SP_BME] && !(freeze && modCfg_q[scp_pkg::MC_FRZ_BM]);
			doubleFaultMonEn_q <= prot_q[scp_pkg::SP_DOUBLE_FAULT_MONITOR_ENABLE];
			portFullIrq_q <= modCfg_q[scp_pkg::MC_FULLIRQ];
			clockLossReset_q <= clockLost && clockLossResetEnable && oscLoopEnable;
			peripheralReset_q <= instrReset;
		end
	end

	// ***************
	// checks
	// ***************
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence seqSvcFirst;
		svcWrite && busWdata[7:0] == scp_pkg::SVC_FIRST;
	endsequence
	sequence seqSvcSecond;
		svcWrite && busWdata[7:0] == scp_pkg::SVC_SECOND;
	endsequence

	chk_invalid_base_out: assert property (busSel && !mbase_q[scp_pkg::MB_VALID] && !hitHi && !hitLo && ce
		|=> busExternal_q && !busAck_q) else $error("access decoded with base invalid");
	chk_masked_space: assert property (busSel && ce && spaceMasked && !hitHi && !hitLo
		|=> !busAck_q) else $error("masked space answered internally");
	chk_user_write_err: assert property (busSel && ce && internalHit && userDenied
		|=> busErr_q && !busAck_q) else $error("user write not refused");
	chk_prot_once: assert property (ce && protWritten_q |=> $stable(prot_q)) else $error("protection rewritten");
	chk_rsr_onehot: assert property (captured_q |-> $onehot(rsr_q)) else $error("reset status not one-hot");
	chk_svc_applies: assert property (ce && svc_q == scp_pkg::SVC_IDLE
		|=> $stable(wdSel_q)) else $error("timeout changed without service");
	chk_svc_sequence: assert property ((ce and seqSvcFirst) ##2 (ce and seqSvcSecond)
		|=> wdCount_q == '0) else $error("service did not restart watchdog");
	chk_wd_action: assert property (ce && wdTimeout && prot_q[scp_pkg::SP_WDRST]
		|=> wdResetReq_q && !$rose(wdIrq7_q)) else $error("watchdog reset not issued");
	chk_autovec_gate: assert property (ce && modCfg_q[3:0] == scp_pkg::ARB_OFF
		|=> !autovectorRequest_q) else $error("autovector with zero priority");
	chk_no_show: assert property (ce && !showOn |=> !showDrive_q && !showDataStrobe_q) else $error("show drive while off");
	chk_arb_block: assert property (ce && !arbOn |=> !extRequestSeen_q) else $error("request seen without arbitration");
endmodule

// >>> tb/scp_far_model.sv
// far side model: outside bus master and crystal source
// assumes the bench clock and reset; one crystal tick per four clocks
`timescale 1ns/1ps
module scp_far_model (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// bench control and block answer
	input wire logic wantBus,
	input wire logic seen,
	// toward the block, and cycle start back to the bench
	output logic extBusRequest,
	output logic crystalTick,
	output logic cycleStarted
);
	logic [1:0] div;
	// ***************
	// crystal source
	// ***************
	// crystal period four clocks
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			div <= 2'h0;
			crystalTick <= 1'b0;
		end else begin
			div <= div + 2'h1;
			crystalTick <= (div == 2'h3);
		end
	end
	// ***************
	// outside master
	// ***************
	// no cycle before recognised
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			extBusRequest <= 1'b0;
			cycleStarted <= 1'b0;
		end else begin
			extBusRequest <= wantBus;
			cycleStarted <= wantBus && seen;
		end
	end
endmodule

// >>> tb/system_config_protection_regs_tb.sv
// self-checking bench for the configuration and protection bank
// assumes scp_pkg and scp_regs; far side from scp_far_model
`timescale 1ns/1ps
module system_config_protection_regs_tb;
	localparam logic [31:0] BASE = 32'h00fff000;
	localparam logic [3:0] SD = scp_pkg::FC_SUP_DATA;
	logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, busSel = 1'b0, busWrite = 1'b0, busUpper = 1'b0, busLower = 1'b0;
	logic [3:0] busFc = 4'h0;
	logic [31:0] busAddr = 32'h0;
	logic [15:0] busWdata = 16'h0;
	logic freeze = 1'b0, iackCycle = 1'b0, iackWatchdog = 1'b0, wantBus = 1'b0, instrReset = 1'b0;
	logic [2:0] iackLevel = 3'h0;
	logic causePin = 1'b1, causePowerUp = 1'b0, causeWatchdog = 1'b0, clockLost = 1'b0;
	logic clockLossResetEnable = 1'b0, oscLoopEnable = 1'b0;
	logic extBusRequest, crystalTick, cycleStarted;
	logic busAck_q, busErr_q, busExternal_q, showDrive_q, showDataStrobe_q, extRequestSeen_q;
	logic [15:0] busRdata_q, showData_q;
	logic timersRun_q, busMonitorRun_q, doubleFaultMonEn_q, portFullIrq_q, iackVectorValid_q;
	logic autovectorRequest_q, iackExtraneous_q, clockLossReset_q, peripheralReset_q, wdResetReq_q, wdIrq7_q;
	logic [7:0] iackVector_q;
	logic rAck, rErr, rExt, rShow, hit;
	logic [15:0] rData;
	int num_errors = 0;
	int cmp_count = 0;
	always #2.5 mclk = ~mclk;
	scp_regs #(.WdShorten(8)) dut_u (.mclk(mclk), .rst(rst), .ce(ce), .busSel(busSel), .busWrite(busWrite),
		.busFc(busFc), .busAddr(busAddr), .busUpper(busUpper), .busLower(busLower), .busWdata(busWdata),
		.busAck_q(busAck_q), .busErr_q(busErr_q), .busExternal_q(busExternal_q), .busRdata_q(busRdata_q),
		.extBusRequest(extBusRequest), .showDrive_q(showDrive_q), .showDataStrobe_q(showDataStrobe_q),
		.showData_q(showData_q), .extRequestSeen_q(extRequestSeen_q), .freeze(freeze),
		.timersRun_q(timersRun_q), .busMonitorRun_q(busMonitorRun_q), .doubleFaultMonEn_q(doubleFaultMonEn_q),
		.portFullIrq_q(portFullIrq_q), .iackCycle(iackCycle), .iackLevel(iackLevel),
		.iackWatchdog(iackWatchdog), .iackVectorValid_q(iackVectorValid_q), .iackVector_q(iackVector_q),
		.autovectorRequest_q(autovectorRequest_q), .iackExtraneous_q(iackExtraneous_q), .causePin(causePin),
		.causePowerUp(causePowerUp), .causeWatchdog(causeWatchdog), .causeDoubleFault(1'b0),
		.causeClockLoss(1'b0), .instrReset(instrReset), .modckStrap(1'b1),
		.clockLossResetEnable(clockLossResetEnable), .oscLoopEnable(oscLoopEnable), .clockLost(clockLost),
		.clockLossReset_q(clockLossReset_q), .peripheralReset_q(peripheralReset_q),
		.crystalTick(crystalTick), .wdResetReq_q(wdResetReq_q), .wdIrq7_q(wdIrq7_q));
	scp_far_model far_u (.mclk(mclk), .rst(rst), .wantBus(wantBus), .seen(extRequestSeen_q),
		.extBusRequest(extBusRequest), .crystalTick(crystalTick), .cycleStarted(cycleStarted));
	// ***************
	// compare and bus tasks
	// ***************
	task automatic cmpv(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmpf(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic acc(input logic [3:0] fc, input logic [31:0] a, input logic wr, input logic [15:0] d,
		input logic [1:0] ln);
		@(posedge mclk);
		busSel <= 1'b1;
		busWrite <= wr;
		busFc <= fc;
		busAddr <= a;
		busWdata <= d;
		busUpper <= ln[1];
		busLower <= ln[0];
		@(posedge mclk);
		busSel <= 1'b0;
		#1;
		rAck = busAck_q;
		rErr = busErr_q;
		rExt = busExternal_q;
		rShow = showDrive_q;
		rData = busRdata_q;
	endtask
	task automatic wr(input logic [11:0] o, input logic [15:0] d);
		acc(SD, BASE | o, 1'b1, d, 2'b11);
	endtask
	task automatic rd(input logic [11:0] o);
		acc(SD, BASE | o, 1'b0, 16'h0, 2'b11);
	endtask
	task automatic ack(input logic [2:0] lv, input logic wd);
		@(posedge mclk);
		iackCycle <= 1'b1;
		iackLevel <= lv;
		iackWatchdog <= wd;
		@(posedge mclk);
		iackCycle <= 1'b0;
		#1;
	endtask
	task automatic wt(input int n, input logic rsel = 1'b0);
		hit = 1'b0;
		for (int i = 0; i < n && !hit; i++) begin
			@(posedge mclk);
			#1;
			hit = ((rsel ? wdResetReq_q : wdIrq7_q) === 1'b1);
		end
	endtask
	task automatic setBase();
		acc(scp_pkg::FC_CPU, scp_pkg::MBASE_ADDR_HI, 1'b1, 16'h00ff, 2'b11);
		acc(scp_pkg::FC_CPU, scp_pkg::MBASE_ADDR_LO, 1'b1, 16'hf001, 2'b11);
	endtask
	// ***************
	// scenarios
	// ***************
	task automatic t_base();
		rd(scp_pkg::OFF_MODCFG);
		cmpf("invalid base external", 1'b1, rExt);
		setBase();
		rd(scp_pkg::OFF_MODCFG);
		cmpv("config reset", 16'h000f, rData);
		rd(scp_pkg::OFF_AVRRSR);
		cmpv("reset status pin", 16'h0080, rData);
		wr(scp_pkg::OFF_AVRRSR, 16'hffff);
		rd(scp_pkg::OFF_AVRRSR);
		cmpv("avr written rsr kept", 16'hfe80, rData);
		rd(scp_pkg::OFF_VECPROT);
		cmpv("vector reset", 16'h0f00, rData);
		acc(SD, BASE | scp_pkg::OFF_VECPROT, 1'b1, 16'h5a00, 2'b10);
		rd(scp_pkg::OFF_VECPROT);
		cmpv("vector written", 16'h5a00, rData);
		acc(scp_pkg::FC_CPU, scp_pkg::MBASE_ADDR_LO, 1'b1, 16'hf041, 2'b11);
		rd(scp_pkg::OFF_MODCFG);
		cmpf("masked space external", 1'b1, rExt);
		acc(4'h1, BASE, 1'b0, 16'h0, 2'b11);
		cmpf("unmasked space internal", 1'b1, rAck);
		acc(scp_pkg::FC_CPU, scp_pkg::MBASE_ADDR_LO, 1'b1, 16'hf001, 2'b11);
	endtask
	task automatic t_supervisor_restrict();
		wr(scp_pkg::OFF_MODCFG, 16'h008f);
		acc(4'h1, BASE, 1'b1, 16'h000f, 2'b11);
		cmpf("user write bus error", 1'b1, rErr);
		rd(scp_pkg::OFF_MODCFG);
		cmpv("user write ignored", 16'h008f, rData);
		wr(scp_pkg::OFF_MODCFG, 16'h000f);
		acc(4'h1, BASE, 1'b1, 16'h000f, 2'b11);
		cmpf("unrestricted user write", 1'b1, rAck);
	endtask
	task automatic t_show();
		wantBus <= 1'b1;
		for (int f = 0; f < 4; f++) begin
			wr(scp_pkg::OFF_MODCFG, {6'h0, 2'(f), 8'h0f});
			cmpf("show strobe", f > 1, showDataStrobe_q);
			cmpv("show data", f > 1 ? {6'h0, 2'(f), 8'h0f} : 16'h0000, showData_q);
			rd(scp_pkg::OFF_MODCFG);
			cmpf("show pulse", f != 0, rShow);
			repeat (3) @(posedge mclk);
			#1;
			cmpf("request seen", f != 1, extRequestSeen_q);
			cmpf("outside cycle started", f != 1, cycleStarted);
		end
		wantBus <= 1'b0;
		wr(scp_pkg::OFF_MODCFG, 16'h000f);
	endtask
	task automatic t_frz();
		wr(scp_pkg::OFF_MODCFG, 16'h700f);
		freeze <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		cmpf("timers frozen", 1'b0, timersRun_q);
		cmpf("monitor frozen", 1'b0, busMonitorRun_q);
		cmpf("full irq port", 1'b1, portFullIrq_q);
		wr(scp_pkg::OFF_MODCFG, 16'h000f);
		repeat (3) @(posedge mclk);
		#1;
		cmpf("timers run in freeze", 1'b1, timersRun_q);
		cmpf("four irq port", 1'b0, portFullIrq_q);
		freeze <= 1'b0;
		ack(3'h3, 1'b0);
		cmpf("autovector", 1'b1, autovectorRequest_q);
		wr(scp_pkg::OFF_MODCFG, 16'h0000);
		ack(3'h3, 1'b0);
		cmpf("no autovector at zero", 1'b0, autovectorRequest_q);
		cmpf("extraneous at zero", 1'b1, iackExtraneous_q);
		wr(scp_pkg::OFF_MODCFG, 16'h000f);
	endtask
	task automatic t_wdog();
		acc(SD, BASE | scp_pkg::OFF_VECPROT, 1'b1, 16'h008c, 2'b01);
		acc(SD, BASE | scp_pkg::OFF_VECPROT, 1'b1, 16'h0000, 2'b01);
		rd(scp_pkg::OFF_VECPROT);
		cmpv("protection write once", 16'h5a8c, rData);
		cmpf("double fault monitor", 1'b1, doubleFaultMonEn_q);
		cmpf("bus monitor on", 1'b1, busMonitorRun_q);
		wr(scp_pkg::OFF_MODCFG, 16'h200f);
		freeze <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		cmpf("monitor frozen by bit", 1'b0, busMonitorRun_q);
		cmpf("timers run in monitor freeze", 1'b1, timersRun_q);
		freeze <= 1'b0;
		wr(scp_pkg::OFF_MODCFG, 16'h000f);
		wt(40);
		cmpf("short timeout irq", 1'b1, hit);
		ack(3'h7, 1'b1);
		cmpv("watchdog vector", 16'h005a, {8'h00, iackVector_q});
		cmpf("watchdog vector valid", 1'b1, iackVectorValid_q);
		wr(scp_pkg::OFF_TIMING, 16'h0200);
		wt(40);
		cmpf("old timeout kept", 1'b1, hit);
		ack(3'h7, 1'b1);
		wr(scp_pkg::OFF_SERVICE, 16'h0055);
		wr(scp_pkg::OFF_SERVICE, 16'h00aa);
		ack(3'h7, 1'b1);
		wt(200);
		cmpf("long timeout not yet", 1'b0, hit);
		wt(4400);
		cmpf("long timeout reached", 1'b1, hit);
		ack(3'h7, 1'b1);
	endtask
	task automatic t_rst();
		clockLossResetEnable <= 1'b1;
		clockLost <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		cmpf("no loss reset loop off", 1'b0, clockLossReset_q);
		oscLoopEnable <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		cmpf("loss reset", 1'b1, clockLossReset_q);
		clockLost <= 1'b0;
		@(posedge mclk);
		instrReset <= 1'b1;
		@(posedge mclk);
		instrReset <= 1'b0;
		#1;
		cmpf("peripheral reset", 1'b1, peripheralReset_q);
		rd(scp_pkg::OFF_MODCFG);
		cmpv("config kept", 16'h000f, rData);
		rd(scp_pkg::OFF_AVRRSR);
		cmpv("instruction reset status", 16'hfe02, rData);
		causePowerUp <= 1'b1;
		causeWatchdog <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		setBase();
		rd(scp_pkg::OFF_AVRRSR);
		cmpv("one source bit", 16'h0040, rData);
		rd(scp_pkg::OFF_VECPROT);
		cmpv("vector and protection reset", 16'h0f00, rData);
		acc(SD, BASE | scp_pkg::OFF_VECPROT, 1'b1, 16'h00c0, 2'b01);
		wt(40, 1'b1);
		cmpf("watchdog reset request", 1'b1, hit);
		cmpf("no irq with reset select", 1'b0, wdIrq7_q);
	endtask
	task automatic test_done();
		$display("comparisons %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		t_base();
		t_supervisor_restrict();
		t_show();
		t_frz();
		t_wdog();
		t_rst();
		test_done();
	end
endmodule
